// ### logic/ltc_top.sv
// line transmitter control: coder, jitter path, alarm insertion, output control, status and irq
`timescale 1ns/1ps
`default_nettype none

module ltc_top #(
   parameter int JA_DEPTH = 32
) (
   input  wire logic             CLOCK_IN,
   input  wire logic             RST_N_IN,
   input  wire logic [12:0]      ADDR_IN,
   input  wire logic [7:0]       WDATA_IN,
   input  wire logic             WR_IN,
   input  wire logic             RD_IN,
   output logic      [7:0]       RDATA_OUT,
   input  wire logic             TX_OUTPUT_ENABLE_PIN_IN,
   input  wire logic             TX_CLK_IN,
   input  wire logic             MCLK_BIT_IN,
   input  wire logic             TX_NRZ_IN,
   input  wire logic             RX_LOS_IN,
   input  wire logic             LIMITER_ACTIVE_IN,
   input  wire logic             OPEN_POS_IN,
   input  wire logic             OPEN_NEG_IN,
   output logic                  TX_LINE_POS_OUT,
   output logic                  TX_LINE_NEG_OUT,
   output logic                  TX_LINE_OE_OUT,
   output logic      [2:0]       PULSE_SHAPE_OUT,
   output logic      [2:0]       TERMINATION_OUT,
   output logic      [1:0]       LINE_MODE_OUT,
   output logic                  TX_POWER_DOWN_OUT,
   output logic                  LIU_RESET_OUT,
   output logic                  IRQ_OUT_N
);

   localparam int PW = $clog2(JA_DEPTH);

   typedef struct packed {
      logic [7:0]  global_transceiver_control_2, gclk, srst, gimr, trcr, tips, mcr, simr, rism;
      logic [2:0]  lts;                 // latched status
      logic        gisr_liu;            // global sticky summary
      logic [7:0]  rdata;
      logic        rd_lts, rd_gisr;     // pending read-clears
      logic        clk_prev, mclk_prev;
      logic [3:0]  zrun;                // zeros run length
      logic        last_pol;            // polarity of last mark
      logic        bp_since_v;          // parity of marks since violation
      logic [3:0][1:0] pipe;            // 4-bit substitution window
      logic [JA_DEPTH-1:0][1:0] ja;
      logic [PW-1:0] ja_wr, ja_rd;
      logic        ais_q;               // alarm state, changes at bit edges
      logic [1:0]  sym;
      logic [2:0]  rts_prev;
   } ltc_state_type;

   ltc_state_type s_q, s_d;

   function automatic logic csu_mode(input logic [2:0] lbo);
      csu_mode = (lbo == ltc_pkg::LBO_CSU_A) || (lbo == ltc_pkg::LBO_CSU_B) ||
                 (lbo == ltc_pkg::LBO_CSU_C);
   endfunction : csu_mode

   logic [2:0] rts;
   logic       tick_tx, tick_m, tick, ais_want, ja_on, hiz, lts_set, gis_set;
   logic [1:0] enc_in, enc_out, code;

   always_comb begin
      rts = '0;
      rts[ltc_pkg::ST_LOS] = RX_LOS_IN;
      rts[ltc_pkg::ST_SC]  = LIMITER_ACTIVE_IN;
      rts[ltc_pkg::ST_OC]  = (OPEN_POS_IN | OPEN_NEG_IN)
                             & ~csu_mode(s_q.tips[ltc_pkg::TIPS_LBO_LO +: 3]);
   end

   assign tick_tx  = TX_CLK_IN & ~s_q.clk_prev;
   assign tick_m   = MCLK_BIT_IN & ~s_q.mclk_prev;
   assign ais_want = s_q.mcr[ltc_pkg::MCR_AIS] |
                     (s_q.mcr[ltc_pkg::MCR_AUTO_AIS] & RX_LOS_IN);
   assign tick     = s_q.ais_q ? tick_m : tick_tx;
   assign code     = s_q.mcr[ltc_pkg::MCR_CODE_LO +: 2];
   assign ja_on    = s_q.trcr[ltc_pkg::TRCR_JA_TX] & s_q.trcr[ltc_pkg::TRCR_JA_EN];
   assign hiz      = ~TX_OUTPUT_ENABLE_PIN_IN
                     | s_q.trcr[ltc_pkg::TRCR_TRI]
                     | s_q.mcr[ltc_pkg::MCR_PWRDN];
   assign enc_out  = s_q.pipe[3];
   assign lts_set  = |(rts & ~s_q.rts_prev);

   // combined next state
   always_comb begin
      logic        mark;
      logic [1:0]  sub;
      s_d = s_q;
      mark = 1'b0;
      sub = 2'b00;
      enc_in = 2'b00;
      s_d.clk_prev  = TX_CLK_IN;
      s_d.mclk_prev = MCLK_BIT_IN;
      s_d.rts_prev  = rts;
      s_d.rdata     = '0;
      s_d.rd_lts    = 1'b0;
      s_d.rd_gisr   = 1'b0;

      // registers
      if (WR_IN) begin
         unique case (ADDR_IN)
            ltc_pkg::OFF_GLOBAL_TRANSCEIVER_CONTROL_2: s_d.global_transceiver_control_2 = WDATA_IN;
            ltc_pkg::OFF_GCLK:  s_d.gclk  = WDATA_IN;
            ltc_pkg::OFF_SRST:  s_d.srst  = WDATA_IN;
            ltc_pkg::OFF_GIMR:  s_d.gimr  = WDATA_IN;
            ltc_pkg::OFF_TRCR:  s_d.trcr  = WDATA_IN;
            ltc_pkg::OFF_TIPS:  s_d.tips  = WDATA_IN;
            ltc_pkg::OFF_MCR:   s_d.mcr   = WDATA_IN;
            ltc_pkg::OFF_SIMR:  s_d.simr  = WDATA_IN;
            ltc_pkg::OFF_RISM:  s_d.rism  = WDATA_IN;
            default: ;
         endcase
      end
      if (RD_IN) begin
         unique case (ADDR_IN)
            ltc_pkg::OFF_GLOBAL_TRANSCEIVER_CONTROL_2: s_d.rdata = s_q.global_transceiver_control_2;
            ltc_pkg::OFF_GCLK:  s_d.rdata = s_q.gclk;
            ltc_pkg::OFF_SRST:  s_d.rdata = s_q.srst;
            ltc_pkg::OFF_GISR: begin
               s_d.rdata = {7'h00, s_q.gisr_liu};
               s_d.rd_gisr = 1'b1;
            end
            ltc_pkg::OFF_GIMR:  s_d.rdata = s_q.gimr;
            ltc_pkg::OFF_TRCR:  s_d.rdata = s_q.trcr;
            ltc_pkg::OFF_TIPS:  s_d.rdata = s_q.tips;
            ltc_pkg::OFF_MCR:   s_d.rdata = s_q.mcr;
            ltc_pkg::OFF_RTS:   s_d.rdata = {5'h00, rts};
            ltc_pkg::OFF_SIMR:  s_d.rdata = s_q.simr;
            ltc_pkg::OFF_LTS: begin
               s_d.rdata = {5'h00, s_q.lts};
               s_d.rd_lts = 1'b1;
            end
            ltc_pkg::OFF_RSL:   s_d.rdata = 8'h00;
            ltc_pkg::OFF_RISM:  s_d.rdata = s_q.rism;
            default:            s_d.rdata = 8'h00;
         endcase
      end

      // read clears the latched bits one cycle after the read strobe; a new edge in that later cycle wins
      s_d.lts = (s_q.rd_lts ? 3'h0 : s_q.lts) | (rts & ~s_q.rts_prev);
      gis_set = |(s_d.lts & s_q.simr[2:0]);
      s_d.gisr_liu = (s_q.rd_gisr ? 1'b0 : s_q.gisr_liu) | (gis_set & lts_set);

      // one bit per bit-clock edge
      if (tick) begin
         s_d.ais_q = ais_want;
         if (s_q.ais_q) begin
            mark = 1'b1;
         end else begin
            mark = TX_NRZ_IN;
         end
         // ami with last-polarity tracking, then substitution on zero runs
         if (mark) begin
            s_d.zrun = 4'h0;
            s_d.last_pol = ~s_q.last_pol;
            sub = s_q.last_pol ? 2'b10 : 2'b01;
            s_d.bp_since_v = ~s_q.bp_since_v;
         end else begin
            s_d.zrun = s_q.zrun + 4'h1;
         end
         s_d.pipe = {s_q.pipe[2:0], sub};
         if (!mark && !s_q.ais_q) begin
            if (code == 2'(ltc_pkg::CODE_HDB3) && s_q.zrun == 4'h3) begin
               // 000V or B00V on the last four bits
               if (s_q.bp_since_v) begin
                  s_d.pipe[0] = s_q.last_pol ? 2'b01 : 2'b10;                 // V same polarity
                  s_d.pipe[3] = 2'b00;
               end else begin
                  s_d.pipe[3] = s_q.last_pol ? 2'b10 : 2'b01;                 // B
                  s_d.pipe[0] = s_q.last_pol ? 2'b10 : 2'b01;                 // V
                  s_d.last_pol = ~s_q.last_pol;
               end
               s_d.bp_since_v = 1'b0;
               s_d.zrun = 4'h0;
            end
            if (code == 2'(ltc_pkg::CODE_B8ZS) && s_q.zrun == 4'h7) begin
               // eight zeros: last four of them become VB0V in window
               s_d.pipe[3] = s_q.last_pol ? 2'b01 : 2'b10;
               s_d.pipe[2] = s_q.last_pol ? 2'b10 : 2'b01;
               s_d.pipe[1] = 2'b00;
               s_d.pipe[0] = s_q.last_pol ? 2'b10 : 2'b01;
               s_d.zrun = 4'h0;
            end
         end
         enc_in = enc_out;
         // jitter buffer: fixed half-depth latency smooths the stream
         s_d.ja[s_q.ja_wr] = enc_in;
         s_d.ja_wr = s_q.ja_wr + PW'(1);
         s_d.ja_rd = s_q.ja_wr - PW'(JA_DEPTH / 2) + PW'(1);
         s_d.sym = ja_on ? s_q.ja[s_q.ja_rd] : enc_in;
      end

      // soft reset clears line datapath and status; the register port stays usable
      if (s_q.srst[ltc_pkg::G_LIU]) begin
         s_d.pipe       = '0;
         s_d.zrun       = '0;
         s_d.sym        = '0;
         s_d.lts        = '0;
         s_d.gisr_liu   = 1'b0;
         s_d.ais_q      = 1'b0;
         s_d.last_pol   = 1'b0;
         s_d.bp_since_v = 1'b0;
         s_d.ja_wr      = '0;
         s_d.ja_rd      = '0;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA_OUT         = s_q.rdata;
   assign TX_LINE_POS_OUT   = s_q.sym[1];
   assign TX_LINE_NEG_OUT   = s_q.sym[0];
   assign TX_LINE_OE_OUT    = ~hiz;
   assign PULSE_SHAPE_OUT   = s_q.tips[ltc_pkg::TIPS_LBO_LO +: 3];
   assign TERMINATION_OUT   = s_q.tips[ltc_pkg::TIPS_IMP_LO +: 3];
   assign LINE_MODE_OUT     = s_q.trcr[ltc_pkg::TRCR_MODE_LO +: 2];
   assign TX_POWER_DOWN_OUT = s_q.mcr[ltc_pkg::MCR_PWRDN];
   assign LIU_RESET_OUT     = s_q.srst[ltc_pkg::G_LIU];
   assign IRQ_OUT_N         = ~(s_q.gisr_liu & s_q.gimr[ltc_pkg::G_LIU]);

endmodule : ltc_top

`default_nettype wire

// ### shared/ltc_pkg.sv
// package: register map, field positions, reset values and types of the line transmitter control
package ltc_pkg;

   localparam int ADDR_W = 13;

   localparam logic [12:0] OFF_GLOBAL_TRANSCEIVER_CONTROL_2  = 13'h00F2;
   localparam logic [12:0] OFF_GCLK   = 13'h00F3;
   localparam logic [12:0] OFF_SRST   = 13'h00F5;
   localparam logic [12:0] OFF_GISR   = 13'h00FB;
   localparam logic [12:0] OFF_GIMR   = 13'h00FE;
   localparam logic [12:0] OFF_TRCR   = 13'h1000;
   localparam logic [12:0] OFF_TIPS   = 13'h1001;
   localparam logic [12:0] OFF_MCR    = 13'h1002;
   localparam logic [12:0] OFF_RTS    = 13'h1003;
   localparam logic [12:0] OFF_SIMR   = 13'h1004;
   localparam logic [12:0] OFF_LTS    = 13'h1005;
   localparam logic [12:0] OFF_RSL    = 13'h1006;
   localparam logic [12:0] OFF_RISM   = 13'h1007;

   // line_tx_rx_control
   localparam int TRCR_MODE_LO = 0;   // 2 bits: line standard
   localparam int TRCR_JA_TX   = 2;   // jitter attenuator in transmit path
   localparam int TRCR_JA_EN   = 3;   // jitter attenuator enable
   localparam int TRCR_TRI     = 4;   // output tri-state
   localparam int TRCR_LOSC    = 5;   // loss criteria select
   // tx_impedance_pulse_select
   localparam int TIPS_LBO_LO  = 0;   // 3 bits: pulse shape
   localparam int TIPS_IMP_LO  = 4;   // 3 bits: termination
   // line_maintenance_control
   localparam int MCR_PWRDN    = 0;   // tx_power_down
   localparam int MCR_AIS      = 1;   // send all ones
   localparam int MCR_AUTO_AIS = 2;   // auto_alarm_on_loss
   localparam int MCR_CODE_LO  = 4;   // 2 bits: line code
   // status layout (real time, latched, mask)
   localparam int ST_LOS = 0;
   localparam int ST_OC  = 1;
   localparam int ST_SC  = 2;
   // global irq / soft reset bit
   localparam int G_LIU  = 0;

   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_RW  = 8'h00;

   typedef enum logic [1:0] {MODE_T1, MODE_J1, MODE_E1_75, MODE_E1_120} ltc_mode_type;
   typedef enum logic [1:0] {CODE_AMI, CODE_B8ZS, CODE_HDB3, CODE_RSV} ltc_code_type;

   // pulse shapes 5..7 are the three T1 CSU build-out modes
   localparam logic [2:0] LBO_CSU_A = 3'h5;
   localparam logic [2:0] LBO_CSU_B = 3'h6;
   localparam logic [2:0] LBO_CSU_C = 3'h7;

   // clock rates in Hz: the 25 MHz system clock and the E1 and T1 bit rates
   localparam int SYS_HZ   = 25000000;
   localparam int E1_HZ    = 2048000;
   localparam int T1_HZ    = 1544000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } ltc_bus_type;

   typedef struct packed {
      logic pos;   // positive mark
      logic neg;   // negative mark
   } ltc_sym_type;

endpackage : ltc_pkg

// ### tb/ltc_top_props.sv
// checker: port-level properties of the line transmitter control
`timescale 1ns/1ps
`default_nettype none
module ltc_top_props (
   input wire logic        CLOCK_IN,
   input wire logic        RST_N_IN,
   input wire logic [12:0] ADDR_IN,
   input wire logic [7:0]  WDATA_IN,
   input wire logic        WR_IN,
   input wire logic        RD_IN,
   input wire logic [7:0]  RDATA_OUT,
   input wire logic        TX_OUTPUT_ENABLE_PIN_IN,
   input wire logic        LIMITER_ACTIVE_IN,
   input wire logic        OPEN_POS_IN,
   input wire logic        OPEN_NEG_IN,
   input wire logic        TX_LINE_POS_OUT,
   input wire logic        TX_LINE_NEG_OUT,
   input wire logic        TX_LINE_OE_OUT,
   input wire logic [2:0]  PULSE_SHAPE_OUT,
   input wire logic [1:0]  LINE_MODE_OUT,
   input wire logic        TX_POWER_DOWN_OUT,
   input wire logic        LIU_RESET_OUT,
   input wire logic        IRQ_OUT_N
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   // detector levels may pass a synchroniser, so only reads after four quiet cycles count
   sequence rts_read(sig);
      ($stable(sig) && !LIU_RESET_OUT) [*4] ##0 (RD_IN && ADDR_IN == ltc_pkg::OFF_RTS);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_pin_tristate: assert property (!TX_OUTPUT_ENABLE_PIN_IN |-> !TX_LINE_OE_OUT)
      else $error("line driven while enable pin low");
   a_pdown_tristate: assert property (TX_POWER_DOWN_OUT |-> !TX_LINE_OE_OUT)
      else $error("line driven while powered down");
   a_marks_apart: assert property (!(TX_LINE_POS_OUT && TX_LINE_NEG_OUT))
      else $error("both marks at once");
   a_short_status: assert property (rts_read(LIMITER_ACTIVE_IN) |=>
      RDATA_OUT[ltc_pkg::ST_SC] == $past(LIMITER_ACTIVE_IN)) else $error("short bit wrong");
   a_open_status: assert property (rts_read({OPEN_POS_IN, OPEN_NEG_IN, PULSE_SHAPE_OUT}) |=>
      RDATA_OUT[ltc_pkg::ST_OC] == (($past(OPEN_POS_IN) || $past(OPEN_NEG_IN)) &&
      $past(PULSE_SHAPE_OUT) < ltc_pkg::LBO_CSU_A)) else $error("open bit wrong");
   a_mode_field: assert property (WR_IN && ADDR_IN == ltc_pkg::OFF_TRCR |=>
      LINE_MODE_OUT == $past(WDATA_IN[1:0])) else $error("line mode not taken");
   a_srst_field: assert property (WR_IN && ADDR_IN == ltc_pkg::OFF_SRST |=>
      LIU_RESET_OUT == $past(WDATA_IN[0])) else $error("soft reset not taken");
   a_irq_release: assert property ($rose(IRQ_OUT_N) |-> $past(RD_IN) || $past(RD_IN, 2) ||
      $past(WR_IN) || $past(WR_IN, 2) || $past(LIU_RESET_OUT)) else $error("irq left alone");
   c_irq_low: cover property ($fell(IRQ_OUT_N));
   c_short_read: cover property (rts_read(LIMITER_ACTIVE_IN) ##1 RDATA_OUT[ltc_pkg::ST_SC]);
   c_line_mark: cover property ($rose(TX_LINE_NEG_OUT) && TX_LINE_OE_OUT);
endmodule : ltc_top_props
`default_nettype wire

// ### tb/ltc_line_model.sv
// partner: framer bit timing and data, line mark counter
`timescale 1ns/1ps
`default_nettype none
module ltc_line_model (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic [1:0]  mode_in,
   input  wire logic        nrz_level_in,
   input  wire logic        pos_in,
   input  wire logic        neg_in,
   input  wire logic        oe_in,
   output logic             tx_clk_out,
   output logic             mclk_out,
   output logic             nrz_out,
   output logic      [15:0] marks_out
);
   int   acc_q;
   int   rate;
   logic pos_q;
   logic neg_q;
   assign rate     = (mode_in >= 2'h2) ? ltc_pkg::E1_HZ : ltc_pkg::T1_HZ;
   assign mclk_out = tx_clk_out;
   assign nrz_out  = nrz_level_in;
   // phase accumulator keeps the average bit rate exact despite the uneven divide
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_q      <= 0;
         tx_clk_out <= 1'b0;
         {pos_q, neg_q, marks_out} <= 18'h00000;
      end else begin
         if (acc_q + 2 * rate >= ltc_pkg::SYS_HZ) begin
            acc_q      <= acc_q + 2 * rate - ltc_pkg::SYS_HZ;
            tx_clk_out <= !tx_clk_out;
         end else begin
            acc_q <= acc_q + 2 * rate;
         end
         {pos_q, neg_q} <= {pos_in, neg_in};
         // only marks put on a driven line reach the far end
         if (oe_in && ((pos_in && !pos_q) || (neg_in && !neg_q))) begin
            marks_out <= marks_out + 16'h0001;
         end
      end
   end
endmodule : ltc_line_model
`default_nettype wire

// ### tb/tb_ltc_top.sv
// testbench: registers, status, interrupt and line behaviour of the line transmitter control
`timescale 1ns/1ps
`default_nettype none
module tb_ltc_top;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b1, los = 1'b0;
   logic        lim = 1'b0, opos = 1'b0, oneg = 1'b0, nrz = 1'b0;
   logic        txc, mck, nrzl, pos, neg, oe, irq_n, pdn, srst;
   logic [12:0] addr = 13'h0000;
   logic [7:0]  wd = 8'h00, rdata;
   logic [2:0]  shape, term;
   logic [1:0]  mode;
   logic [15:0] marks, m0;
   int          mismatches = 0, comparisons = 0;
   always #20 clk = !clk;
   ltc_top ltc_top_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TX_OUTPUT_ENABLE_PIN_IN(pin),
      .TX_CLK_IN(txc), .MCLK_BIT_IN(mck), .TX_NRZ_IN(nrzl), .RX_LOS_IN(los),
      .LIMITER_ACTIVE_IN(lim), .OPEN_POS_IN(opos), .OPEN_NEG_IN(oneg), .TX_LINE_POS_OUT(pos),
      .TX_LINE_NEG_OUT(neg), .TX_LINE_OE_OUT(oe), .PULSE_SHAPE_OUT(shape), .TERMINATION_OUT(term),
      .LINE_MODE_OUT(mode), .TX_POWER_DOWN_OUT(pdn), .LIU_RESET_OUT(srst), .IRQ_OUT_N(irq_n));
   ltc_line_model ltc_line_model_inst (.clock_in(clk), .rst_n_in(rst_n), .mode_in(mode),
      .nrz_level_in(nrz), .pos_in(pos), .neg_in(neg), .oe_in(oe), .tx_clk_out(txc),
      .mclk_out(mck), .nrz_out(nrzl), .marks_out(marks));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
      @(posedge clk);
      {addr, wd, wr} <= {a, d, 1'b1};
      idle(1);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input string what, input logic [12:0] a, input logic [7:0] exp);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      idle(1);
      rd <= 1'b0;
      chk(what, rdata, exp);
   endtask : rd_chk
   // many: at least 30 marks in 400 cycles, about 33 bit times at the e1 rate
   task automatic ones_chk(input logic many);
      idle(300);
      m0 = marks;
      idle(400);
      chk("marks", 16'(marks - m0 >= 16'd30), 16'(many));
   endtask : ones_chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("rst", ltc_pkg::OFF_LTS, ltc_pkg::RST_REG);
      rd_chk("rst", ltc_pkg::OFF_GISR, ltc_pkg::RST_REG);
      rd_chk("unmapped", 13'h0100, 8'h00);
      wr_reg(ltc_pkg::OFF_TRCR, 8'h03);
      rd_chk("trcr", ltc_pkg::OFF_TRCR, 8'h03);
      wr_reg(ltc_pkg::OFF_TIPS, 8'h35);
      chk("fields", {term, shape, mode, oe}, 16'h00EF);
      pin <= 1'b0;
      idle(1);
      chk("pin", oe, 1'b0);
      pin <= 1'b1;
      wr_reg(ltc_pkg::OFF_TRCR, 8'h13);
      chk("tri", oe, 1'b0);
      wr_reg(ltc_pkg::OFF_TRCR, 8'h03);
      wr_reg(ltc_pkg::OFF_MCR, 8'h01);
      chk("pdown", {pdn, oe}, 2'h2);
      wr_reg(ltc_pkg::OFF_MCR, 8'h00);
      wr_reg(ltc_pkg::OFF_SIMR, 8'h04);
      wr_reg(ltc_pkg::OFF_GIMR, 8'h01);
      lim <= 1'b1;
      idle(8);
      chk("irq", irq_n, 1'b0);
      rd_chk("short", ltc_pkg::OFF_RTS, 8'h04);
      lim <= 1'b0;
      idle(8);
      rd_chk("short", ltc_pkg::OFF_RTS, 8'h00);
      chk("irq", irq_n, 1'b0);
      rd_chk("global", ltc_pkg::OFF_GISR, 8'h01);
      rd_chk("sticky", ltc_pkg::OFF_LTS, 8'h04);
      idle(4);
      chk("irq", irq_n, 1'b1);
      rd_chk("clear", ltc_pkg::OFF_LTS, 8'h00);
      opos <= 1'b1;
      for (int s = 5; s < 8; s++) begin
         wr_reg(ltc_pkg::OFF_TIPS, 8'h30 | 8'(s));
         idle(6);
         rd_chk("csu", ltc_pkg::OFF_RTS, 8'h00);
      end
      wr_reg(ltc_pkg::OFF_TIPS, 8'h30);
      {opos, oneg} <= 2'h1;
      idle(8);
      rd_chk("open", ltc_pkg::OFF_RTS, 8'h02);
      rd_chk("open", ltc_pkg::OFF_LTS, 8'h02);
      chk("masked", irq_n, 1'b1);
      oneg <= 1'b0;
      for (int c = 2; c >= 0; c--) begin
         wr_reg(ltc_pkg::OFF_MCR, 8'h02 | 8'(c << 4));
         ones_chk(1'b1);
      end
      wr_reg(ltc_pkg::OFF_MCR, 8'h00);
      ones_chk(1'b0);
      nrz <= 1'b1;
      ones_chk(1'b1);
      nrz <= 1'b0;
      wr_reg(ltc_pkg::OFF_MCR, 8'h04);
      los <= 1'b1;
      ones_chk(1'b1);
      wr_reg(ltc_pkg::OFF_TRCR, 8'h0F);
      wr_reg(ltc_pkg::OFF_MCR, 8'h02);
      ones_chk(1'b1);
      wr_reg(ltc_pkg::OFF_SRST, 8'h01);
      chk("srst", srst, 1'b1);
      rd_chk("srst", ltc_pkg::OFF_LTS, 8'h00);
      rd_chk("setup", ltc_pkg::OFF_TRCR, 8'h0F);
      ones_chk(1'b0);
      wr_reg(ltc_pkg::OFF_SRST, 8'h00);
      chk("srst", srst, 1'b0);
      ones_chk(1'b1);
      end_of_test();
   end
endmodule : tb_ltc_top
bind ltc_top ltc_top_props ltc_top_props_inst (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
   .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .TX_OUTPUT_ENABLE_PIN_IN(TX_OUTPUT_ENABLE_PIN_IN), .LIMITER_ACTIVE_IN(LIMITER_ACTIVE_IN),
   .OPEN_POS_IN(OPEN_POS_IN), .OPEN_NEG_IN(OPEN_NEG_IN), .TX_LINE_POS_OUT(TX_LINE_POS_OUT),
   .TX_LINE_NEG_OUT(TX_LINE_NEG_OUT), .TX_LINE_OE_OUT(TX_LINE_OE_OUT),
   .PULSE_SHAPE_OUT(PULSE_SHAPE_OUT), .LINE_MODE_OUT(LINE_MODE_OUT),
   .TX_POWER_DOWN_OUT(TX_POWER_DOWN_OUT), .LIU_RESET_OUT(LIU_RESET_OUT), .IRQ_OUT_N(IRQ_OUT_N));
`default_nettype wire
